/* File: logic/rbgic_pkg.sv */
// Constants for the random bit generator control and interrupt block.
package rbgic_pkg;
  localparam int          NUM_SOURCES      = 4;
  localparam int          OSC_PER_SOURCE   = 16;
  localparam int          THR_W            = 3;
  localparam int          CNT_W            = 4;
  localparam int          FIFO_DEPTH       = 8;
  localparam int          STAT_W           = 8;
  localparam int          STAT_DATA_READY_FLAG_BIT    = 1;
  localparam int          STAT_ERR_BIT     = 2;
  localparam logic [2:0]  THR_RESET        = 3'h7;
  localparam logic [15:0] OSC_EN_RESET     = 16'hffff;
  localparam logic        IE_DATA_READY_FLAG_RESET    = 1'h1;
  localparam logic        IE_ERR_RESET     = 1'h0;
  localparam logic [1:0]  MODE_TRUE        = 2'h0;
  localparam logic [1:0]  MODE_DET         = 2'h1;
endpackage : rbgic_pkg

/* File: logic/rbgic_top.sv */
// Control, FIFO and interrupt logic of the random bit generator.
//
// Operation
// - Two interrupts, each gated by its control enable: empty-read error and data-ready.
// - Data-ready interrupt enable is set after reset.
// - While generator is disabled, pending flags are never cleared.
// - Write one clears empty-read flag; each later empty read sets it again.
// - Write one to data-ready flag deasserts the data-ready interrupt.
// - Data-ready raised only when active FIFO count reaches programmed threshold.
// - Data-ready is edge triggered on reaching threshold, not level.
// - FIFO status reports number of words held.
// - Configuration writes other than mode have no effect while the generator is enabled.
// - Mode switch between true and deterministic works at run time.
// - Four ring-oscillator sources with post-processing feed the single FIFO.
// - Sampling clock is system clock when select high, own oscillator when low.
// - All oscillator enables on after reset; software may toggle each one.
// - Threshold is three bits, resets to seven, fires on count threshold-1 to threshold.
// - Status holds data-ready at bit one, empty-read error at bit two, write-one-clear.
// - Each source has sixteen oscillators with own enable, all resetting to one.
`timescale 1ns/1ps
module rbgic_top #(
  parameter int DATA_W = 32,
  parameter int DEPTH  = rbgic_pkg::FIFO_DEPTH
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_srst,
  input  wire logic                 i_ce,
  input  wire logic                 i_gen_enable,
  input  wire logic                 i_ie_data_ready_flag_wr,
  input  wire logic                 i_ie_data_ready_flag,
  input  wire logic                 i_ie_err_wr,
  input  wire logic                 i_ie_err,
  input  wire logic                 i_cfg_wr,
  input  wire logic [2:0]           i_true_thr,
  input  wire logic [2:0]           i_det_thr,
  input  wire logic [63:0]          i_osc_en,
  input  wire logic                 i_mode_wr,
  input  wire logic                 i_mode_det,
  input  wire logic                 i_sclk_sel,
  input  wire logic [3:0]           i_ring_osc_clock,
  input  wire logic [63:0]          i_osc_bits,
  input  wire logic                 i_data_rd,
  input  wire logic                 i_status_wr,
  input  wire logic [7:0]           i_status_wdata,
  output logic [DATA_W-1:0]         o_random_data_out_reg,
  output logic [7:0]                o_generator_status_reg,
  output logic [3:0]                o_fifo_count,
  output logic                      o_fifo_empty,
  output logic [2:0]                o_true_fifo_threshold,
  output logic [2:0]                o_det_fifo_threshold,
  output logic [63:0]               o_osc_enables,
  output logic                      o_ie_data_ready_flag,
  output logic                      o_ie_err,
  output logic                      o_det_mode,
  output logic                      o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration: frozen while the generator runs, except the mode.
  logic [2:0]  true_thr_reg;
  logic [2:0]  det_thr_reg;
  logic [63:0] osc_en_reg;
  logic        ie_data_ready_flag_reg;
  logic        ie_err_reg;
  logic        mode_det_reg;
  wire         cfg_open = !i_gen_enable;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      true_thr_reg <= rbgic_pkg::THR_RESET;
      det_thr_reg  <= rbgic_pkg::THR_RESET;
      osc_en_reg   <= {4{rbgic_pkg::OSC_EN_RESET}};
      ie_data_ready_flag_reg  <= rbgic_pkg::IE_DATA_READY_FLAG_RESET;
      ie_err_reg   <= rbgic_pkg::IE_ERR_RESET;
      mode_det_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_cfg_wr && cfg_open)
      begin
        true_thr_reg <= i_true_thr;
        det_thr_reg  <= i_det_thr;
        osc_en_reg   <= i_osc_en;
      end
      if (i_ie_data_ready_flag_wr && cfg_open)
        ie_data_ready_flag_reg <= i_ie_data_ready_flag;
      if (i_ie_err_wr && cfg_open)
        ie_err_reg <= i_ie_err;
      // Mode may change while running, unlike the rest of the configuration.
      if (i_mode_wr)
        mode_det_reg <= i_mode_det;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entropy: four sources, each sampling its sixteen enabled oscillators.
  // The oscillator clocks are treated as synchronous samples here; the select
  // picks the system clock or a rising oscillator clock level as the sample gate.
  logic [3:0]  samp_q_reg;
  logic [3:0]  samp_reg;
  logic [3:0]  raw_bit;
  logic [DATA_W-1:0] shift_reg;
  logic [5:0]  nbits_reg;
  logic [31:0] lfsr_reg;
  genvar s;
  generate
    for (s = 0; s < rbgic_pkg::NUM_SOURCES; s++)
    begin : g_src
      assign raw_bit[s] = ^(i_osc_bits[s*16 +: 16] & osc_en_reg[s*16 +: 16]);
    end
  endgenerate
  // Sample strobe per source: every cycle, or on a rising oscillator level.
  wire [3:0] samp_ok = i_sclk_sel ? 4'hf : (samp_reg & ~samp_q_reg);
  wire       post_bit = ^(raw_bit & samp_ok);
  wire       lfsr_fb  = lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0];
  wire       gen_bit  = mode_det_reg ? lfsr_fb : post_bit;
  wire       word_ok  = (nbits_reg == 6'(DATA_W - 1));

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      samp_reg   <= 4'h0;
      samp_q_reg <= 4'h0;
      shift_reg  <= '0;
      nbits_reg  <= 6'h00;
      lfsr_reg   <= 32'h0000_0001;
    end
    else if (i_ce)
    begin
      samp_reg   <= i_ring_osc_clock;
      samp_q_reg <= samp_reg;
      if (i_gen_enable)
      begin
        lfsr_reg  <= {lfsr_reg[30:0], lfsr_fb};
        shift_reg <= {shift_reg[DATA_W-2:0], gen_bit};
        nbits_reg <= word_ok ? 6'h00 : nbits_reg + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active FIFO: one storage serves whichever mode is selected.
  logic [DATA_W-1:0] mem [DEPTH];
  logic [2:0]  wptr_reg;
  logic [2:0]  rptr_reg;
  logic [3:0]  cnt_reg;
  wire  empty   = (cnt_reg == 4'h0);
  wire  full    = (cnt_reg == 4'(DEPTH));
  wire  push    = i_gen_enable && word_ok && !full;
  wire  pop     = i_data_rd && !empty;
  wire  emp_rd  = i_data_rd && empty;
  wire [3:0] cnt_next = cnt_reg + {3'h0, push} - {3'h0, pop};
  wire [2:0] thr  = mode_det_reg ? det_thr_reg : true_thr_reg;
  // Fires only on the step from one below threshold up to threshold.
  wire  hit_thr = (cnt_next == {1'b0, thr}) && (cnt_reg == {1'b0, thr} - 4'h1);

  always_ff @(posedge i_clk_sys)
  begin
    // A low clock enable must not let the storage run ahead of its pointers.
    if (i_ce && push)
      mem[wptr_reg] <= shift_reg;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      wptr_reg <= 3'h0;
      rptr_reg <= 3'h0;
      cnt_reg  <= 4'h0;
      o_random_data_out_reg <= '0;
    end
    else if (i_ce)
    begin
      if (push)
        wptr_reg <= wptr_reg + 3'h1;
      if (pop)
      begin
        rptr_reg <= rptr_reg + 3'h1;
        o_random_data_out_reg <= mem[rptr_reg];
      end
      cnt_reg <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: set wins over clear; clears only act while the generator runs.
  logic data_ready_flag_reg;
  logic err_reg;
  wire  clr_ok   = i_status_wr && i_gen_enable;
  wire  data_ready_flag_next = hit_thr || (data_ready_flag_reg && !(clr_ok && i_status_wdata[rbgic_pkg::STAT_DATA_READY_FLAG_BIT]));
  wire  err_next  = emp_rd || (err_reg && !(clr_ok && i_status_wdata[rbgic_pkg::STAT_ERR_BIT]));

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      data_ready_flag_reg <= 1'b0;
      err_reg  <= 1'b0;
      o_irq    <= 1'b0;
    end
    else if (i_ce)
    begin
      data_ready_flag_reg <= data_ready_flag_next;
      err_reg  <= err_next;
      o_irq    <= (data_ready_flag_next && ie_data_ready_flag_reg) || (err_next && ie_err_reg);
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_generator_status_reg <= 8'h00;
      o_fifo_count          <= 4'h0;
      o_fifo_empty          <= 1'b1;
      o_true_fifo_threshold <= rbgic_pkg::THR_RESET;
      o_det_fifo_threshold  <= rbgic_pkg::THR_RESET;
      o_osc_enables         <= {4{rbgic_pkg::OSC_EN_RESET}};
      o_ie_data_ready_flag             <= rbgic_pkg::IE_DATA_READY_FLAG_RESET;
      o_ie_err              <= rbgic_pkg::IE_ERR_RESET;
      o_det_mode            <= 1'b0;
    end
    else if (i_ce)
    begin
      o_generator_status_reg <= {5'h00, err_next, data_ready_flag_next, 1'b0};
      o_fifo_count          <= cnt_next;
      o_fifo_empty          <= (cnt_next == 4'h0);
      o_true_fifo_threshold <= true_thr_reg;
      o_det_fifo_threshold  <= det_thr_reg;
      o_osc_enables         <= osc_en_reg;
      o_ie_data_ready_flag             <= ie_data_ready_flag_reg;
      o_ie_err              <= ie_err_reg;
      o_det_mode            <= mode_det_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  data_ready_flag_edge_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    ($rose(data_ready_flag_reg) && $stable(thr)) |->
      (cnt_reg == {1'b0, thr}) && ($past(cnt_reg) == {1'b0, thr} - 4'h1))
    else $error("data-ready rose without reaching threshold");
  hold_off_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_ce && !i_gen_enable && data_ready_flag_reg) |=> data_ready_flag_reg)
    else $error("data-ready cleared while disabled");
  err_set_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_ce && emp_rd) |=> err_reg && o_generator_status_reg[rbgic_pkg::STAT_ERR_BIT])
    else $error("empty read did not flag error");
  err_clr_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_ce && err_reg && clr_ok && i_status_wdata[2] && !emp_rd) |=> !err_reg)
    else $error("error flag not cleared");
  data_ready_flag_clr_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_ce && clr_ok && i_status_wdata[1] && !hit_thr) |=> !data_ready_flag_reg)
    else $error("data-ready flag not cleared");
  cfg_lock_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_gen_enable && $past(i_gen_enable)) |-> $stable(true_thr_reg) && $stable(osc_en_reg))
    else $error("configuration changed while enabled");
  pop_cnt_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_ce && pop && !push) |=> cnt_reg == $past(cnt_reg) - 4'h1)
    else $error("pop did not decrement count");
  irq_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_ce && data_ready_flag_next && ie_data_ready_flag_reg) |=> o_irq)
    else $error("enabled data-ready not on interrupt");
  ie_reset_a: assert property (@(posedge i_clk_sys)
    ($past(i_srst) && !i_srst) |-> ie_data_ready_flag_reg)
    else $error("data-ready enable not set after reset");
endmodule : rbgic_top

/* File: verif/random_bit_gen_irq_control_bench.sv */
// Self-checking bench for the random bit generator control and interrupt block.
`timescale 1ns/1ps
module random_bit_gen_irq_control_bench;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        gen_en = 1'b0;
  logic        ie_data_ready_flag_wr = 1'b0;
  logic        ie_data_ready_flag = 1'b0;
  logic        ie_err_wr = 1'b0;
  logic        ie_err = 1'b0;
  logic        cfg_wr = 1'b0;
  logic [2:0]  tthr = 3'h0;
  logic [2:0]  dthr = 3'h0;
  logic [63:0] osc_en = 64'h0;
  logic        mode_wr = 1'b0;
  logic        mode_det = 1'b0;
  logic [3:0]  osc_clk = 4'h0;
  logic        sclk_sel = 1'b1;
  logic        hold = 1'b0;
  logic [63:0] osc_bits = 64'h9e37_79b9_7f4a_7c15;
  logic        rd = 1'b0;
  logic        st_wr = 1'b0;
  logic [7:0]  st_wd = 8'h00;
  logic [31:0] data;
  logic [31:0] d0;
  logic [7:0]  status;
  logic [3:0]  cnt;
  logic        empty;
  logic [2:0]  o_tthr;
  logic [2:0]  o_dthr;
  logic [63:0] o_osc;
  logic        o_ie_data_ready_flag;
  logic        o_ie_err;
  logic        det;
  logic        irq;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cycles = 0;
  typedef struct packed {logic [2:0] tt; logic [2:0] dt; logic [63:0] en;} rbgic_row_s;
  rbgic_row_s  rows [3] = '{'{3'h0, 3'h7, 64'h0000_ffff_0000_ffff}, '{3'h7, 3'h0, 64'h8001_4002_2004_1008},
                            '{3'h3, 3'h5, 64'hffff_ffff_ffff_ffff}};
  rbgic_top uut (.i_clk_sys(clk), .i_srst(srst), .i_ce(1'b1), .i_gen_enable(gen_en), .i_ie_data_ready_flag_wr(ie_data_ready_flag_wr),
    .i_ie_data_ready_flag(ie_data_ready_flag), .i_ie_err_wr(ie_err_wr), .i_ie_err(ie_err), .i_cfg_wr(cfg_wr), .i_true_thr(tthr),
    .i_det_thr(dthr), .i_osc_en(osc_en), .i_mode_wr(mode_wr), .i_mode_det(mode_det), .i_sclk_sel(sclk_sel),
    .i_ring_osc_clock(osc_clk), .i_osc_bits(osc_bits), .i_data_rd(rd), .i_status_wr(st_wr), .i_status_wdata(st_wd),
    .o_random_data_out_reg(data), .o_generator_status_reg(status), .o_fifo_count(cnt), .o_fifo_empty(empty),
    .o_true_fifo_threshold(o_tthr), .o_det_fifo_threshold(o_dthr), .o_osc_enables(o_osc), .o_ie_data_ready_flag(o_ie_data_ready_flag),
    .o_ie_err(o_ie_err), .o_det_mode(det), .o_irq(irq));
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Oscillator levels keep moving so that the sampled bits are never constant,
  // unless held so that a word depends on the sampling-clock select alone.
  always @(posedge clk)
  begin
    osc_bits <= hold ? 64'h0000_0000_0000_0001 : {osc_bits[62:0], osc_bits[63] ^ osc_bits[60]};
    osc_clk  <= hold ? osc_clk : osc_clk + 4'h1;
    cycles   <= cycles + 1;
    if (cycles == 5000)
    begin
      n_fail++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic rd_pulse();
    @(posedge clk) rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    step(2);
  endtask : rd_pulse
  task automatic st_clear(input logic [7:0] v);
    @(posedge clk) begin st_wr <= 1'b1; st_wd <= v; end
    @(posedge clk) st_wr <= 1'b0;
    step(2);
  endtask : st_clear
  task automatic cfg(input rbgic_row_s r);
    @(posedge clk) begin cfg_wr <= 1'b1; tthr <= r.tt; dthr <= r.dt; osc_en <= r.en; end
    @(posedge clk) cfg_wr <= 1'b0;
    step(2);
  endtask : cfg
  // Waiting for a count bounds the hang if the generator never produces words.
  task automatic wait_cnt(input logic [3:0] n);
    for (int i = 0; i < 300 && cnt !== n; i++)
      step(1);
  endtask : wait_cnt
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    step(12);
    @(posedge clk) srst <= 1'b0;
    step(1);
    chk("status", status, 64'h0);
    chk("count", cnt, 64'h0);
    chk("empty", empty, 64'h1);
    chk("true_thr", o_tthr, 64'h7);
    chk("det_thr", o_dthr, 64'h7);
    chk("osc_en", o_osc, 64'hffff_ffff_ffff_ffff);
    chk("ie_data_ready_flag", o_ie_data_ready_flag, 64'h1);
    chk("irq", irq, 64'h0);
    foreach (rows[k])
    begin
      cfg(rows[k]);
      chk("row_true_thr", o_tthr, rows[k].tt);
      chk("row_det_thr", o_dthr, rows[k].dt);
      chk("row_osc_en", o_osc, rows[k].en);
    end
    @(posedge clk) begin ie_err_wr <= 1'b1; ie_err <= 1'b1; end
    @(posedge clk) ie_err_wr <= 1'b0;
    step(2);
    chk("ie_err_set", o_ie_err, 64'h1);
    chk("clean_start", status, 64'h0);
    @(posedge clk) gen_en <= 1'b1;
    cfg('{3'h1, 3'h1, 64'h0});
    chk("locked_thr", o_tthr, 64'h3);
    chk("locked_osc", o_osc, 64'hffff_ffff_ffff_ffff);
    @(posedge clk) begin ie_err_wr <= 1'b1; ie_err <= 1'b0; end
    @(posedge clk) ie_err_wr <= 1'b0;
    step(2);
    chk("locked_ie", o_ie_err, 64'h1);
    d0 = data;
    for (int k = 0; k < 2; k++)
    begin
      rd_pulse();
      chk("err_flag", status[2], 64'h1);
      chk("err_irq", irq, 64'h1);
      chk("err_data", data, d0);
      st_clear(8'h04);
      chk("err_clear", status[2], 64'h0);
    end
    @(posedge clk) begin mode_wr <= 1'b1; mode_det <= 1'b1; end
    @(posedge clk) mode_det <= 1'b0;
    @(posedge clk) mode_wr <= 1'b0;
    step(2);
    chk("mode_back", det, 64'h0);
    wait_cnt(4'h2);
    chk("below_thr", status[1], 64'h0);
    wait_cnt(4'h3);
    step(2);
    chk("data_ready_flag_rise", status[1], 64'h1);
    chk("data_ready_flag_irq", irq, 64'h1);
    st_clear(8'h02);
    chk("data_ready_flag_clear", status[1], 64'h0);
    wait_cnt(4'h4);
    step(2);
    chk("above_thr", status[1], 64'h0);
    wait_cnt(4'h5);
    rd_pulse();
    chk("pop_count", cnt, 64'h4);
    for (int i = 0; i < 20 && cnt !== 4'h2; i++)
      rd_pulse();
    wait_cnt(4'h3);
    step(2);
    chk("data_ready_flag_again", status[1], 64'h1);
    @(posedge clk) gen_en <= 1'b0;
    st_clear(8'h06);
    chk("hold_pending", status[1], 64'h1);
    // Held levels and one enabled oscillator: a word is all ones while the system clock
    // samples, and all zeros while the frozen oscillator clock gives no sampling edge.
    @(posedge clk) hold <= 1'b1;
    for (int i = 0; i < 20 && cnt !== 4'h0; i++)
      rd_pulse();
    cfg('{3'h0, 3'h2, 64'h0000_0000_0000_0001});
    @(posedge clk) gen_en <= 1'b1;
    st_clear(8'h06);
    chk("restart_clear", status, 64'h0);
    wait_cnt(4'h2);
    @(posedge clk) sclk_sel <= 1'b0;
    wait_cnt(4'h4);
    repeat (2) rd_pulse();
    chk("word_ones", data, 64'hffff_ffff);
    repeat (2) rd_pulse();
    chk("word_zeros", data, 64'h0);
    chk("thr_zero", status[1], 64'h0);
    for (int i = 0; i < 20 && cnt !== 4'h0; i++)
      rd_pulse();
    @(posedge clk) begin mode_wr <= 1'b1; mode_det <= 1'b1; end
    @(posedge clk) mode_wr <= 1'b0;
    step(2);
    chk("mode_det", det, 64'h1);
    chk("det_below", status[1], 64'h0);
    wait_cnt(4'h2);
    step(2);
    chk("det_thr_hit", status[1], 64'h1);
    stop_test();
  end
endmodule : random_bit_gen_irq_control_bench
